// >>> logic/twm_defines.vh
`ifndef TWM_DEFINES_VH
`define TWM_DEFINES_VH
// Register byte addresses (printed offsets are word aligned)
`define TWM_OFF_CTRL_A   8'h80
`define TWM_OFF_CTRL_B   8'h84
`define TWM_OFF_CMP_A    8'h88
`define TWM_OFF_CMP_B    8'h8c
`define TWM_OFF_CAPTURE  8'h90
`define TWM_OFF_COUNT    8'h94
`define TWM_OFF_FLAGS    8'h98
`define TWM_OFF_PIN_DIR  8'h9c
`define TWM_OFF_TICK_DIV 8'ha0
// Control A fields
`define TWM_CA_ACT_A_HI  7
`define TWM_CA_ACT_A_LO  6
`define TWM_CA_ACT_B_HI  5
`define TWM_CA_ACT_B_LO  4
// Control B fields
`define TWM_CB_SEL_HI    4
`define TWM_CB_SEL_LO    3
// Flag bit positions
`define TWM_FLG_OVF      0
`define TWM_FLG_MATCH_A  1
`define TWM_FLG_MATCH_B  2
// Reset values
`define TWM_RST_CTRL     8'h00
`define TWM_RST_TICK_DIV 16'h0000
// Fixed TOP values
`define TWM_TOP_MAX      16'hffff
`define TWM_TOP_8BIT     16'h00ff
`define TWM_TOP_9BIT     16'h01ff
`define TWM_TOP_10BIT    16'h03ff
// AXI responses
`define TWM_RESP_OKAY    2'b00
`define TWM_RESP_SLVERR  2'b10
`endif

// >>> logic/twm_tick_div.v
`timescale 1ns/1ps
// Timer tick generator: one-cycle enable every (div+1) clocks
module twm_tick_div (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Control
  input  wire        run,
  input  wire [15:0] div,
  // Tick enable out
  output reg         tick
);
  reg [15:0] cnt_q;  // Divider count

  // Counter rolls at div; tick is the clock enable, never a clock
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_q >= div) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule

// >>> logic/twm_wave_out.v
`timescale 1ns/1ps
// One compare-output channel: decodes action code per mode class
module twm_wave_out (
  // Clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // Mode class and action code
  input  wire       is_fast,
  input  wire       is_dual,
  input  wire       toggle_ok,
  input  wire [1:0] action,
  // Events match, at_bottom, at_top qualified by the tick; direction and compare levels are not
  input  wire       match,
  input  wire       match_up,
  input  wire       at_bottom,
  input  wire       cmp_is_top,
  input  wire       cmp_is_zero,
  input  wire       at_top,
  // Pin direction and waveform
  input  wire       dir_out,
  output reg        wave,
  output wire       pin_oe,
  output wire       pin_override
);
  assign pin_override = |action;
  assign pin_oe = pin_override & dir_out;

  // Waveform register update
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wave <= 1'b0;
    end else if (is_fast) begin
      if (action == 2'b01) begin
        if (toggle_ok && match)
          wave <= ~wave;
      end else if (action[1]) begin
        if (match && !cmp_is_top)
          wave <= action[0];
        else if (at_bottom)
          wave <= ~action[0];
      end
    end else if (is_dual) begin
      if (action == 2'b01) begin
        if (toggle_ok && match)
          wave <= ~wave;
      end else if (action[1]) begin
        // clear action: compare at BOTTOM holds low, at TOP holds high; set action the reverse
        if (cmp_is_zero && at_bottom)
          wave <= action[0];
        else if (cmp_is_top && at_top)
          wave <= ~action[0];
        else if (match)
          wave <= match_up ? action[0] : ~action[0];
      end
    end else begin
      if (match) begin
        case (action)
          2'b01:   wave <= ~wave;
          2'b10:   wave <= 1'b0;
          2'b11:   wave <= 1'b1;
          default: wave <= wave;
        endcase
      end
    end
  end
endmodule

// >>> logic/twm_timer16_wave.v
`timescale 1ns/1ps
// What this block does
// - Tick is clock enable, single clock
// - Freq-correct loads compare at BOTTOM
// - Nonzero action overrides pin control
// - Pin driven only if direction output
// - Non-PWM: off, toggle, clear, set
// - Fast PWM toggle only A, modes 14/15
// - Fast PWM clear/set match, opposite at BOTTOM
// - Fast PWM compare==TOP ignores match
// - Dual-slope toggle only A, modes 9/11
// - Dual-slope up/down match actions opposite
// - Mode select split across A and B
// - Modes 0,4,12 immediate, overflow at MAX
// - Modes 1-3 fixed TOP, dual slope
// - Modes 5-7 fast PWM fixed TOP
// - Modes 8,9 load and overflow at BOTTOM
// - Modes 10,11 load TOP, overflow BOTTOM
// - Dual slope extremes hold output level
// - Counter holds TOP one tick
`include "twm_defines.vh"
module twm_timer16_wave (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Waveform pins
  output wire        wave_out_a,
  output wire        wave_oe_a,
  output wire        wave_override_a,
  output wire        wave_out_b,
  output wire        wave_oe_b,
  output wire        wave_override_b
);
  // Mode classes
  localparam CLS_NORMAL = 2'd0;
  localparam CLS_FAST   = 2'd1;
  localparam CLS_DUAL   = 2'd2;

  // Software registers
  reg  [7:0]  ctrl_a_q;       // timer_wave_control_a
  reg  [7:0]  ctrl_b_q;       // timer_wave_control_b
  reg  [15:0] cmp_a_buf_q;    // Written compare A
  reg  [15:0] cmp_b_buf_q;    // Written compare B
  reg  [15:0] cmp_a_q;        // Active compare A
  reg  [15:0] cmp_b_q;        // Active compare B
  reg  [15:0] capture_q;      // capture_value
  reg  [15:0] count_q;        // count_value
  reg         down_q;         // Counting down
  reg  [2:0]  flags_q;        // Overflow and match flags
  reg  [1:0]  pin_dir_q;      // Pin direction bits
  reg  [15:0] tick_div_q;     // Tick divisor
  reg         run_q;          // Timer enabled
  reg         block_q;        // Suppress match after count write
  reg         eq_a_q;         // Equality seen, pending tick
  reg         eq_b_q;
  wire        tick;           // Timer tick enable

  wire [3:0] wave_gen_select = {ctrl_b_q[`TWM_CB_SEL_HI:`TWM_CB_SEL_LO], ctrl_a_q[1:0]};

  // Mode class decode
  function [1:0] mode_class;
    input [3:0] m;
    begin
      case (m)
        4'd1, 4'd2, 4'd3, 4'd8, 4'd9, 4'd10, 4'd11: mode_class = CLS_DUAL;
        4'd5, 4'd6, 4'd7, 4'd14, 4'd15:             mode_class = CLS_FAST;
        default:                                    mode_class = CLS_NORMAL;
      endcase
    end
  endfunction

  function [15:0] top_of;
    input [3:0]  m;
    input [15:0] ca;
    input [15:0] cap;
    begin
      case (m)
        4'd1, 4'd5:               top_of = `TWM_TOP_8BIT;
        4'd2, 4'd6:               top_of = `TWM_TOP_9BIT;
        4'd3, 4'd7:               top_of = `TWM_TOP_10BIT;
        4'd4, 4'd9, 4'd11, 4'd15: top_of = ca;
        4'd8, 4'd10, 4'd12, 4'd14: top_of = cap;
        default:                  top_of = `TWM_TOP_MAX;
      endcase
    end
  endfunction

  wire [1:0]  cls      = mode_class(wave_gen_select);
  wire        is_fast  = (cls == CLS_FAST);
  wire        is_dual  = (cls == CLS_DUAL);
  wire        pfc      = (wave_gen_select == 4'd8) || (wave_gen_select == 4'd9);
  // TOP uses the active compare A (buffered in PWM modes)
  wire [15:0] top      = top_of(wave_gen_select, cmp_a_q, capture_q);
  wire        at_top   = (count_q == top);
  wire        at_bot   = (count_q == 16'h0000);
  wire        at_max   = (count_q == `TWM_TOP_MAX);
  // mode 13 falls to normal counting, not guaranteed

  twm_tick_div u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (run_q),
    .div     (tick_div_q),
    .tick    (tick)
  );

  // Compare buffer load points
  wire immediate = (cls == CLS_NORMAL);
  // BOTTOM load for freq-correct and fast
  wire load_now  = immediate | (tick & ((is_fast | pfc) ? at_bot : (is_dual & at_top)));

  // Overflow set point per mode
  wire ovf_set = tick & (is_fast ? at_top : (is_dual ? at_bot : at_max));

  // AXI handshake state
  reg         aw_have_q, w_have_q;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire        wr_go  = aw_have_q && w_have_q;
  wire        wr_hit = (aw_addr_q >= `TWM_OFF_CTRL_A) && (aw_addr_q <= `TWM_OFF_TICK_DIV) &&
                       (aw_addr_q[1:0] == 2'b00);
  wire [15:0] wd16   = {w_strb_q[1] ? w_data_q[15:8] : 8'h00, w_strb_q[0] ? w_data_q[7:0] : 8'h00};
  wire        wr_cnt = wr_go && (aw_addr_q == `TWM_OFF_COUNT) && w_strb_q[0];
  wire        wr_flg = wr_go && (aw_addr_q == `TWM_OFF_FLAGS) && w_strb_q[0];

  // Write channel capture and response
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `TWM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `TWM_RESP_OKAY : `TWM_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register writes; byte lanes 0 and 1, plus lane 2 for the run bit
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_a_q    <= `TWM_RST_CTRL;
      ctrl_b_q    <= `TWM_RST_CTRL;
      cmp_a_buf_q <= 16'h0000;
      cmp_b_buf_q <= 16'h0000;
      capture_q   <= 16'h0000;
      pin_dir_q   <= 2'b00;
      tick_div_q  <= `TWM_RST_TICK_DIV;
      run_q       <= 1'b0;
    end else if (wr_go && w_strb_q[0]) begin
      case (aw_addr_q)
        // Bits 3:2 read only zero
        `TWM_OFF_CTRL_A:   ctrl_a_q <= w_data_q[7:0] & 8'hf3;
        // Only selector bits kept here
        `TWM_OFF_CTRL_B:   ctrl_b_q <= w_data_q[7:0] & 8'h18;
        `TWM_OFF_CMP_A:    cmp_a_buf_q <= wd16;
        `TWM_OFF_CMP_B:    cmp_b_buf_q <= wd16;
        `TWM_OFF_CAPTURE:  capture_q <= wd16;
        `TWM_OFF_PIN_DIR:  pin_dir_q <= w_data_q[1:0];
        `TWM_OFF_TICK_DIV: begin
          tick_div_q <= wd16;
          run_q      <= w_data_q[16] & w_strb_q[2];
        end
        default: ;
      endcase
    end
  end

  // Compare double buffer transfer
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmp_a_q <= 16'h0000;
      cmp_b_q <= 16'h0000;
    end else if (load_now) begin
      cmp_a_q <= cmp_a_buf_q;
      cmp_b_q <= cmp_b_buf_q;
    end
  end

  // Counter sequencing
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= 16'h0000;
      down_q  <= 1'b0;
    end else if (wr_cnt) begin
      count_q <= wd16;
    end else if (tick) begin
      if (is_dual) begin
        // TOP held one tick, then reverse
        if (!down_q && at_top) begin
          // Step off TOP at once so it shows for one tick only
          down_q  <= 1'b1;
          count_q <= count_q - 16'h0001;
        end else if (down_q && at_bot) begin
          down_q  <= 1'b0;
          count_q <= 16'h0001;
        end else if (down_q) begin
          count_q <= count_q - 16'h0001;
        end else begin
          count_q <= count_q + 16'h0001;
        end
      end else begin
        down_q  <= 1'b0;
        count_q <= at_top ? 16'h0000 : count_q + 16'h0001;
      end
    end
  end

  // equality latched, flag on next tick
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      eq_a_q  <= 1'b0;
      eq_b_q  <= 1'b0;
      block_q <= 1'b0;
    end else if (wr_cnt) begin
      // Count write blocks the next match
      block_q <= 1'b1;
      eq_a_q  <= 1'b0;
      eq_b_q  <= 1'b0;
    end else if (tick) begin
      block_q <= 1'b0;
      eq_a_q  <= !block_q && (count_q == cmp_a_q);
      eq_b_q  <= !block_q && (count_q == cmp_b_q);
    end
  end
  wire match_a = tick & eq_a_q;
  wire match_b = tick & eq_b_q;

  // Flags: set wins over write-one-to-clear
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags_q <= 3'b000;
    end else begin
      flags_q <= (flags_q & ~(wr_flg ? w_data_q[2:0] : 3'b000)) | {match_b, match_a, ovf_set};
    end
  end

  // Channel outputs; B never toggles in PWM
  twm_wave_out u_ch_a (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .is_fast      (is_fast),
    .is_dual      (is_dual),
    .toggle_ok    (wave_gen_select == 4'd14 || wave_gen_select == 4'd15 ||
                   wave_gen_select == 4'd9 || wave_gen_select == 4'd11),
    .action       (ctrl_a_q[`TWM_CA_ACT_A_HI:`TWM_CA_ACT_A_LO]),
    .match        (match_a),
    .match_up     (!down_q),
    .at_bottom    (tick & at_bot),
    .cmp_is_top   (cmp_a_q == top),
    .cmp_is_zero  (cmp_a_q == 16'h0000),
    .at_top       (tick & at_top),
    .dir_out      (pin_dir_q[0]),
    .wave         (wave_out_a),
    .pin_oe       (wave_oe_a),
    .pin_override (wave_override_a)
  );
  twm_wave_out u_ch_b (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .is_fast      (is_fast),
    .is_dual      (is_dual),
    .toggle_ok    (1'b0),
    .action       (ctrl_a_q[`TWM_CA_ACT_B_HI:`TWM_CA_ACT_B_LO]),
    .match        (match_b),
    .match_up     (!down_q),
    .at_bottom    (tick & at_bot),
    .cmp_is_top   (cmp_b_q == top),
    .cmp_is_zero  (cmp_b_q == 16'h0000),
    .at_top       (tick & at_top),
    .dir_out      (pin_dir_q[1]),
    .wave         (wave_out_b),
    .pin_oe       (wave_oe_b),
    .pin_override (wave_override_b)
  );

  // Read channel: one-cycle registered answer
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `TWM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `TWM_RESP_OKAY;
      case (s_axi_araddr)
        `TWM_OFF_CTRL_A:   s_axi_rdata <= {24'h000000, ctrl_a_q};
        `TWM_OFF_CTRL_B:   s_axi_rdata <= {24'h000000, ctrl_b_q};
        `TWM_OFF_CMP_A:    s_axi_rdata <= {16'h0000, cmp_a_buf_q};
        `TWM_OFF_CMP_B:    s_axi_rdata <= {16'h0000, cmp_b_buf_q};
        `TWM_OFF_CAPTURE:  s_axi_rdata <= {16'h0000, capture_q};
        `TWM_OFF_COUNT:    s_axi_rdata <= {16'h0000, count_q};
        `TWM_OFF_FLAGS:    s_axi_rdata <= {29'h0000000, flags_q};
        `TWM_OFF_PIN_DIR:  s_axi_rdata <= {30'h0000000, pin_dir_q};
        `TWM_OFF_TICK_DIV: s_axi_rdata <= {15'h000, run_q, tick_div_q};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `TWM_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// >>> bench/twm_props_properties.sv
`timescale 1ns/1ps
// Bus handshake and pin-driver checks seen at the block's ports
module twm_props (
  // Clock and reset
  input logic clk,
  input logic sys_rst,
  // Register bus handshakes
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  // Waveform pins
  input logic wave_out_a,
  input logic wave_oe_a,
  input logic wave_override_a,
  input logic wave_oe_b,
  input logic wave_override_b
);
  // One clock domain, so one default clocking and disable
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_OE_A: assert property (wave_oe_a |-> wave_override_a)
    else $error("Pin A driver enabled while port logic owns it");
  AST_OE_B: assert property (wave_oe_b |-> wave_override_b)
    else $error("Pin B driver enabled while port logic owns it");
  // Past reset is excluded: the field returns to zero there without a write
  AST_OVR_A: assert property ($changed(wave_override_a) && !$past(sys_rst) |-> $rose(s_axi_bvalid))
    else $error("Pin A takeover changed without a register write");
  AST_OVR_B: assert property ($changed(wave_override_b) && !$past(sys_rst) |-> $rose(s_axi_bvalid))
    else $error("Pin B takeover changed without a register write");
  // Both taken, write lands one edge later, response seen the edge after
  AST_B_ANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("Write response missing two cycles after address and data");
  AST_B_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("Write response repeated after its handshake");
  AST_R_ANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read data missing one cycle after address");
  AST_R_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("Read data repeated after its handshake");
  AST_AR_BLK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address accepted while data still pending");

  // Main traffic seen
  COV_WR: cover property (s_axi_bvalid && s_axi_bready);
  COV_RD: cover property (s_axi_rvalid && s_axi_rready);
  COV_WAVE: cover property ($rose(wave_out_a));
endmodule

bind twm_timer16_wave twm_props u_props (
  .clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .wave_out_a,
  .wave_oe_a, .wave_override_a, .wave_oe_b, .wave_override_b
);

// >>> bench/tb_twm_timer16_wave.sv
`timescale 1ns/1ps
`include "twm_defines.vh"
module tb_twm_timer16_wave;
  // Stimulus, all set at time zero
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  // Design answers
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  wire         wave_out_a, wave_oe_a, wave_override_a, wave_out_b, wave_oe_b, wave_override_b;
  // Scoreboard and last bus answer
  int          fail_count = 0;
  int          check_count = 0;
  logic [31:0] rv;
  logic [1:0]  rs;
  int          h, l;

  twm_timer16_wave uut (
    .clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wave_out_a, .wave_oe_a, .wave_override_a, .wave_out_b, .wave_oe_b, .wave_override_b
  );

  // 100 ns clock
  initial begin
    forever #50 clk = ~clk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    // Ready seen at the falling edge is what the next rising edge samples
    while (!b) begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask

  // Read: data and response kept in rv and rs
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      r = s_axi_rvalid;
      rv = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask

  // Set up a mode; compare A written in mode 0 so it loads at once
  task automatic cfg(input logic [3:0] m, input logic [1:0] act, input logic [15:0] ca, input logic [15:0] cap);
    wr(`TWM_OFF_CTRL_A, 32'h0);
    wr(`TWM_OFF_CTRL_B, 32'h0);
    wr(`TWM_OFF_CMP_A, {16'h0, ca});
    wr(`TWM_OFF_CAPTURE, {16'h0, cap});
    wr(`TWM_OFF_CTRL_B, {27'h0, m[3:2], 3'h0});
    wr(`TWM_OFF_CTRL_A, {24'h0, act, 4'h0, m[1:0]});
    wr(`TWM_OFF_COUNT, 32'h0);
  endtask

  // Cycles until pin A reaches a level, bounded
  task automatic lvl(input logic v, output int n);
    n = 0;
    while (wave_out_a !== v && n < 5000) begin
      @(negedge clk);
      n++;
    end
  endtask

  // High and low times of pin A after two settling periods
  task automatic run(input logic [3:0] m, input logic [1:0] act, input logic [15:0] ca, input logic [15:0] cap,
                     input int eh, input int el);
    cfg(m, act, ca, cap);
    repeat (2) begin
      lvl(1'b0, h);
      lvl(1'b1, h);
    end
    lvl(1'b0, h);
    lvl(1'b1, l);
    chk(h, eh);
    chk(l, el);
  endtask

  // Pin A must not move; level checked only when e is below 2
  task automatic hold(input logic [3:0] m, input logic [1:0] act, input logic [15:0] ca, input logic [15:0] cap,
                      input logic [1:0] e);
    int n;
    logic v;
    cfg(m, act, ca, cap);
    repeat (300) @(negedge clk);
    v = wave_out_a;
    n = 0;
    repeat (600) begin
      @(negedge clk);
      if (wave_out_a !== v) n++;
      v = wave_out_a;
    end
    chk(n, 0);
    if (e < 2) chk({31'h0, v}, {31'h0, e[0]});
  endtask

  // Counts, verdict, end of run
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run
  initial begin
    #6_000_000;
    fail_count++;
    print_verdict();
  end

  initial begin
    logic [2:0] c;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    // Reset values and unmapped places
    rd(`TWM_OFF_CTRL_A);
    chk(rv, 32'h0);
    rd(`TWM_OFF_CTRL_B);
    chk(rv, 32'h0);
    rd(8'h00);
    chk({30'h0, rs}, {30'h0, `TWM_RESP_SLVERR});
    chk(rv, 32'h0);
    wr(8'h04, 32'hff);
    chk({30'h0, rs}, {30'h0, `TWM_RESP_SLVERR});
    // Mode select split, unused bits read zero
    wr(`TWM_OFF_CTRL_A, 32'hff);
    rd(`TWM_OFF_CTRL_A);
    chk(rv, 32'hf3);
    wr(`TWM_OFF_CTRL_B, 32'hff);
    rd(`TWM_OFF_CTRL_B);
    chk(rv, 32'h18);
    wr(`TWM_OFF_CTRL_B, 32'h0);
    // Every action code against both pin directions
    for (c = 3'd0; c < 3'd4; c++) begin
      wr(`TWM_OFF_CTRL_A, {24'h0, c[1:0], c[1:0], 4'h0});
      wr(`TWM_OFF_PIN_DIR, 32'h0);
      chk({31'h0, wave_override_a}, {31'h0, c != 3'd0});
      chk({31'h0, wave_override_b}, {31'h0, c != 3'd0});
      chk({31'h0, wave_oe_a}, 32'h0);
      wr(`TWM_OFF_PIN_DIR, 32'h3);
      chk({31'h0, wave_oe_a}, {31'h0, c != 3'd0});
      chk({31'h0, wave_oe_b}, {31'h0, c != 3'd0});
    end
    // Tick every clock
    wr(`TWM_OFF_TICK_DIV, 32'h10000);
    // Fixed TOP periods and duty
    run(4'd1, 2'd2, 16'd16, 16'd0, 32, 478);
    run(4'd2, 2'd2, 16'd16, 16'd0, 32, 990);
    run(4'd3, 2'd2, 16'd16, 16'd0, 32, 2014);
    run(4'd5, 2'd2, 16'd16, 16'd0, 17, 239);
    run(4'd6, 2'd2, 16'd16, 16'd0, 17, 495);
    run(4'd7, 2'd2, 16'd16, 16'd0, 17, 1007);
    // Register-defined TOP
    run(4'd14, 2'd2, 16'd16, 16'd39, 17, 23);
    run(4'd14, 2'd3, 16'd16, 16'd39, 23, 17);
    run(4'd8, 2'd2, 16'd16, 16'd39, 32, 46);
    run(4'd10, 2'd2, 16'd16, 16'd39, 32, 46);
    run(4'd10, 2'd3, 16'd16, 16'd39, 46, 32);
    // Toggle on match
    run(4'd4, 2'd1, 16'd39, 16'd0, 40, 40);
    run(4'd12, 2'd1, 16'd0, 16'd39, 40, 40);
    run(4'd15, 2'd1, 16'd39, 16'd0, 40, 40);
    run(4'd9, 2'd1, 16'd39, 16'd0, 78, 78);
    run(4'd11, 2'd1, 16'd39, 16'd0, 78, 78);
    // Steady outputs
    hold(4'd4, 2'd2, 16'd39, 16'd0, 2'd0);
    hold(4'd4, 2'd3, 16'd39, 16'd0, 2'd1);
    hold(4'd14, 2'd2, 16'd39, 16'd39, 2'd1);
    hold(4'd10, 2'd2, 16'd0, 16'd39, 2'd0);
    hold(4'd10, 2'd2, 16'd39, 16'd39, 2'd1);
    hold(4'd10, 2'd3, 16'd0, 16'd39, 2'd1);
    hold(4'd5, 2'd1, 16'd16, 16'd0, 2'd2);
    hold(4'd1, 2'd1, 16'd16, 16'd0, 2'd2);
    // Pin B set, then clear, on its match at zero
    cfg(4'd4, 2'd0, 16'd39, 16'd0);
    wr(`TWM_OFF_CTRL_A, 32'h30);
    repeat (100) @(negedge clk);
    chk({31'h0, wave_out_b}, 32'h1);
    wr(`TWM_OFF_CTRL_A, 32'h20);
    repeat (100) @(negedge clk);
    chk({31'h0, wave_out_b}, 32'h0);
    // Overflow at TOP in fast PWM, not before MAX in clear-on-match
    cfg(4'd15, 2'd0, 16'd39, 16'd0);
    wr(`TWM_OFF_FLAGS, 32'h7);
    repeat (100) @(negedge clk);
    rd(`TWM_OFF_FLAGS);
    chk({31'h0, rv[0]}, 32'h1);
    chk({31'h0, rv[1]}, 32'h1);
    chk({31'h0, rv[2]}, 32'h1);
    cfg(4'd12, 2'd0, 16'd5, 16'd39);
    wr(`TWM_OFF_FLAGS, 32'h7);
    repeat (100) @(negedge clk);
    rd(`TWM_OFF_FLAGS);
    chk({31'h0, rv[0]}, 32'h0);
    chk({31'h0, rv[1]}, 32'h1);
    // No tick, no flags
    wr(`TWM_OFF_TICK_DIV, 32'h0);
    wr(`TWM_OFF_FLAGS, 32'h7);
    repeat (100) @(negedge clk);
    rd(`TWM_OFF_FLAGS);
    chk({29'h0, rv[2:0]}, 32'h0);
    print_verdict();
  end
endmodule
